// File: core/charger_cfg_pkg.sv
// Constants, register map and encodings for the charger configuration bank.
// Assumes a single 25 MHz clock and a synchronous active-low reset.
// Contract
// RL1 - Auto detect bit starts detection on plug-in
// RL2 - Two-bit code selects 60/80/100/120 C limit
// RL3 - Charge enable bit; charge wins over boost
// RL4 - Precharge exit threshold 2.8V or 3.0V
// RL5 - Recharge offset 50..200mV, kept over watchdog
// RL6 - Pulse mode disable bit, kept over watchdog
// RL7 - Kick bit restarts watchdog, then self-clears
// RL8 - Top-off timer off, 15, 30, 45 minutes
// RL9 - Register 07h reserved bits read 0010b
// RL10 - Warm zone voltage: suspend, 8.0V, 8.3V, hold
// RL11 - Warm zone current 40% or 100%
// RL12 - Cool zone current suspend, 20, 40, 100%
// RL13 - Register 09h always reads zero
// RL14 - Register 06h bit 7 reads zero
// RL15 - Reset values 7Dh, 00h, 0Dh
// RL16 - Register 08h top three bits read zero
// RL17 - Watchdog 40/80/160s, expiry restores fields
// RL18 - Reserved writes ignored, fields update per byte
package charger_cfg_pkg;
   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [7:0] ADDR_CTL_B = 8'h06;
   localparam logic [7:0] ADDR_CTL_C = 8'h07;
   localparam logic [7:0] ADDR_ZONE = 8'h08;
   localparam logic [7:0] ADDR_RSVD = 8'h09;
   localparam logic [7:0] ADDR_OPT = 8'h0a;
   localparam logic [7:0] RST_CTL_B = 8'h7d;
   localparam logic [7:0] RST_CTL_C = 8'h00;
   localparam logic [7:0] RST_ZONE = 8'h0d;
   localparam logic [3:0] CTL_C_RSVD_READ = 4'h2;
   // Field positions
   localparam int AUTO_BIT = 6;
   localparam int TLIM_LSB = 4;
   localparam int CHG_BIT = 3;
   localparam int LOWV_BIT = 2;
   localparam int RECHG_LSB = 0;
   localparam int PFM_BIT = 7;
   localparam int KICK_BIT = 6;
   localparam int TOPOFF_LSB = 4;
   localparam int VSET_LSB = 3;
   localparam int ISETH_BIT = 2;
   localparam int ISETC_LSB = 0;
   // ***************************************************************
   // Encodings
   // ***************************************************************
   localparam logic [7:0] TEMP_C_00 = 8'h3c;
   localparam logic [7:0] TEMP_C_01 = 8'h50;
   localparam logic [7:0] TEMP_C_10 = 8'h64;
   localparam logic [7:0] TEMP_C_11 = 8'h78;
   localparam logic [11:0] LOWV_MV_0 = 12'haf0;
   localparam logic [11:0] LOWV_MV_1 = 12'hbb8;
   localparam logic [7:0] RECHG_BASE_MV = 8'h32;
   localparam logic [7:0] RECHG_B1_MV = 8'h64;
   localparam logic [7:0] RECHG_B0_MV = 8'h32;
   localparam logic [5:0] TOPOFF_MIN_01 = 6'h0f;
   localparam logic [5:0] TOPOFF_MIN_10 = 6'h1e;
   localparam logic [5:0] TOPOFF_MIN_11 = 6'h2d;
   localparam logic [13:0] WARM_MV_01 = 14'h1f40;
   localparam logic [13:0] WARM_MV_10 = 14'h206c;
   localparam logic [6:0] PCT_20 = 7'h14;
   localparam logic [6:0] PCT_40 = 7'h28;
   localparam logic [6:0] PCT_100 = 7'h64;
   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int CLK_HZ = 25_000_000;
   localparam logic [7:0] WD_S_01 = 8'd40;
   localparam logic [7:0] WD_S_10 = 8'd80;
   localparam logic [7:0] WD_S_11 = 8'd160;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_ACK = 3'b011,
      S_RX = 3'b010,
      S_TX = 3'b110,
      S_TACK = 3'b111
   } i2c_state_t;
endpackage

// File: core/watchdog_timer.sv
// Host watchdog: counts whole seconds, pulses on expiry.
// Assumes restart_i and period_i are synchronous to clk_i.
`timescale 1ns/1ns
module watchdog_timer #(
   parameter int TICKS_PER_SEC = charger_cfg_pkg::CLK_HZ
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic restart_i,
   input wire logic [1:0] period_i,
   output logic expire_o
);
   logic [31:0] tick_q;
   logic [7:0] sec_q;
   logic [7:0] limit;
   logic sec_end;
   // [RL17]
   assign limit = (period_i == 2'b01) ? charger_cfg_pkg::WD_S_01 :
                  (period_i == 2'b10) ? charger_cfg_pkg::WD_S_10 :
                  charger_cfg_pkg::WD_S_11;
   assign sec_end = (tick_q == 32'(TICKS_PER_SEC - 1));

   always_ff @(posedge clk_i) begin
      if (!nrst_i || restart_i || period_i == 2'b00 || expire_o) begin
         tick_q <= 32'h0;
         sec_q <= 8'h0;
         expire_o <= 1'b0;
      end else if (sec_end) begin
         tick_q <= 32'h0;
         sec_q <= sec_q + 8'h1;
         expire_o <= (sec_q + 8'h1 == limit);
      end else begin
         tick_q <= tick_q + 32'h1;
      end
   end
endmodule

// File: core/i2c_reg_port.sv
// Byte-oriented I2C target: pointer byte, then writes or reads with auto-increment.
// Assumes scl_i and sda_i are already synchronous; sda driven low via sda_oe_o.
`timescale 1ns/1ns
module i2c_reg_port #(
   parameter logic [6:0] DEV_ADDR = 7'h55  // Arbitrary target address
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   input wire logic [7:0] rd_data_i,
   output logic [7:0] ptr_o,
   output logic wr_o,
   output logic [7:0] wr_data_o
);
   charger_cfg_pkg::i2c_state_t st_q;
   logic scl_q, sda_q, rd_q, first_q, ack_q, inc_q;
   logic [3:0] bcnt_q;
   logic [7:0] sh_q;
   logic start, stop, rise, fall;
   assign start = scl_i & scl_q & sda_q & ~sda_i;
   assign stop = scl_i & scl_q & ~sda_q & sda_i;
   assign rise = scl_i & ~scl_q;
   assign fall = ~scl_i & scl_q;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_q <= charger_cfg_pkg::S_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         {rd_q, first_q, ack_q, inc_q, sda_oe_o, wr_o} <= 6'h00;
         bcnt_q <= 4'h0;
         sh_q <= 8'h0;
         ptr_o <= 8'h0;
         wr_data_o <= 8'h0;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
         wr_o <= 1'b0;
         if (start) begin
            st_q <= charger_cfg_pkg::S_ADDR;
            bcnt_q <= 4'h0;
            first_q <= 1'b1;
            inc_q <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (stop) begin
            st_q <= charger_cfg_pkg::S_IDLE;
            sda_oe_o <= 1'b0;
         end else begin
            case (st_q)
               charger_cfg_pkg::S_ADDR, charger_cfg_pkg::S_RX: begin
                  if (rise) begin
                     sh_q <= {sh_q[6:0], sda_i};
                     bcnt_q <= bcnt_q + 4'h1;
                  end else if (fall && bcnt_q == 4'h8) begin
                     st_q <= charger_cfg_pkg::S_ACK;
                     sda_oe_o <= 1'b1;
                     if (st_q == charger_cfg_pkg::S_ADDR) begin
                        rd_q <= sh_q[0];
                        if (sh_q[7:1] != DEV_ADDR) begin
                           st_q <= charger_cfg_pkg::S_IDLE;
                           sda_oe_o <= 1'b0;
                        end
                     end else if (first_q) begin
                        ptr_o <= sh_q;
                        first_q <= 1'b0;
                     end else begin
                        // Whole byte lands at once [RL18]
                        wr_o <= 1'b1;
                        wr_data_o <= sh_q;
                        // Pointer moves on later, the write pulse still uses it
                        inc_q <= 1'b1;
                     end
                  end
               end
               charger_cfg_pkg::S_ACK: begin
                  if (fall) begin
                     bcnt_q <= 4'h0;
                     inc_q <= 1'b0;
                     if (inc_q) begin
                        ptr_o <= ptr_o + 8'h1;
                     end
                     if (rd_q) begin
                        st_q <= charger_cfg_pkg::S_TX;
                        sh_q <= rd_data_i;
                        sda_oe_o <= ~rd_data_i[7];
                     end else begin
                        st_q <= charger_cfg_pkg::S_RX;
                        sda_oe_o <= 1'b0;
                     end
                  end
               end
               charger_cfg_pkg::S_TX: begin
                  if (rise) begin
                     bcnt_q <= bcnt_q + 4'h1;
                  end else if (fall && bcnt_q == 4'h8) begin
                     st_q <= charger_cfg_pkg::S_TACK;
                     sda_oe_o <= 1'b0;
                     ptr_o <= ptr_o + 8'h1;
                  end else if (fall) begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_oe_o <= ~sh_q[6];
                  end
               end
               charger_cfg_pkg::S_TACK: begin
                  if (rise) begin
                     ack_q <= ~sda_i;
                  end else if (fall) begin
                     bcnt_q <= 4'h0;
                     st_q <= ack_q ? charger_cfg_pkg::S_TX : charger_cfg_pkg::S_IDLE;
                     sh_q <= rd_data_i;
                     sda_oe_o <= ack_q & ~rd_data_i[7];
                  end
               end
               default: st_q <= charger_cfg_pkg::S_IDLE;
            endcase
         end
      end
   end
endmodule

// File: core/charger_control_config_regs.sv
// Charger configuration bank at 06h..0Ah behind an I2C target, with watchdog.
// Assumes all inputs synchronous to clk_i; sda wire resolved outside from sda_oe_o.
`timescale 1ns/1ns
module charger_control_config_regs #(
   parameter logic [6:0] DEV_ADDR = 7'h55,  // Arbitrary target address
   parameter int TICKS_PER_SEC = charger_cfg_pkg::CLK_HZ
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic reg_reset_cmd_i,
   input wire logic [1:0] watchdog_period_i,
   input wire logic supply_present_i,
   input wire logic reverse_boost_enable_i,
   input wire logic [4:0] optimizer_limit_i,
   output logic detect_start_o,
   output logic [7:0] die_temp_limit_o,
   output logic charge_enable_o,
   output logic boost_enable_o,
   output logic [11:0] precharge_exit_mv_o,
   output logic [7:0] recharge_offset_mv_o,
   output logic pulse_mode_allowed_o,
   output logic topoff_enable_o,
   output logic [5:0] topoff_minutes_o,
   output logic warm_suspend_o,
   output logic warm_voltage_hold_o,
   output logic [13:0] warm_voltage_mv_o,
   output logic [6:0] warm_current_pct_o,
   output logic cool_suspend_o,
   output logic [6:0] cool_current_pct_o,
   output logic watchdog_expired_o
);
   // ***************************************************************
   // Bus port and watchdog
   // ***************************************************************
   logic [7:0] ptr, wr_data, rdata_q;
   logic wr, wd_expire;
   logic sda_oe_q;

   i2c_reg_port #(.DEV_ADDR(DEV_ADDR)) u_port (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_o(sda_oe_q),
      .rd_data_i(rdata_q),
      .ptr_o(ptr),
      .wr_o(wr),
      .wr_data_o(wr_data)
   );
   assign sda_oe_o = sda_oe_q;
   assign sda_o = 1'b0;

   // ***************************************************************
   // Field storage
   // ***************************************************************
   logic auto_q, chg_q, lowv_q, pfm_q, kick_q, iseth_q;
   logic [1:0] tlim_q, rechg_q, topoff_q, vset_q, isetc_q;
   logic wr_b, wr_c, wr_z, kick_set;
   logic [7:0] img_b, img_c, img_z, rdata_d;

   watchdog_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_wd (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .restart_i(kick_q),  // [RL7]
      .period_i(watchdog_period_i),
      .expire_o(wd_expire)
   );

   assign wr_b = wr & (ptr == charger_cfg_pkg::ADDR_CTL_B);
   assign wr_c = wr & (ptr == charger_cfg_pkg::ADDR_CTL_C);
   assign wr_z = wr & (ptr == charger_cfg_pkg::ADDR_ZONE);
   assign kick_set = wr_c & wr_data[charger_cfg_pkg::KICK_BIT];

   // Fields restored to reset values by both the reset command and watchdog expiry
   always_ff @(posedge clk_i) begin
      if (!nrst_i || reg_reset_cmd_i || wd_expire) begin  // [RL15] [RL17]
         auto_q <= charger_cfg_pkg::RST_CTL_B[charger_cfg_pkg::AUTO_BIT];
         tlim_q <= charger_cfg_pkg::RST_CTL_B[charger_cfg_pkg::TLIM_LSB +: 2];
         chg_q <= charger_cfg_pkg::RST_CTL_B[charger_cfg_pkg::CHG_BIT];
         lowv_q <= charger_cfg_pkg::RST_CTL_B[charger_cfg_pkg::LOWV_BIT];
         topoff_q <= charger_cfg_pkg::RST_CTL_C[charger_cfg_pkg::TOPOFF_LSB +: 2];
         vset_q <= charger_cfg_pkg::RST_ZONE[charger_cfg_pkg::VSET_LSB +: 2];
         iseth_q <= charger_cfg_pkg::RST_ZONE[charger_cfg_pkg::ISETH_BIT];
         isetc_q <= charger_cfg_pkg::RST_ZONE[charger_cfg_pkg::ISETC_LSB +: 2];
      end else begin
         if (wr_b) begin  // [RL18]
            auto_q <= wr_data[charger_cfg_pkg::AUTO_BIT];
            tlim_q <= wr_data[charger_cfg_pkg::TLIM_LSB +: 2];
            chg_q <= wr_data[charger_cfg_pkg::CHG_BIT];
            lowv_q <= wr_data[charger_cfg_pkg::LOWV_BIT];
         end
         if (wr_c) begin
            topoff_q <= wr_data[charger_cfg_pkg::TOPOFF_LSB +: 2];
         end
         if (wr_z) begin
            vset_q <= wr_data[charger_cfg_pkg::VSET_LSB +: 2];
            iseth_q <= wr_data[charger_cfg_pkg::ISETH_BIT];
            isetc_q <= wr_data[charger_cfg_pkg::ISETC_LSB +: 2];
         end
      end
   end

   // Fields that survive watchdog expiry
   always_ff @(posedge clk_i) begin
      if (!nrst_i || reg_reset_cmd_i) begin  // [RL5] [RL6]
         rechg_q <= charger_cfg_pkg::RST_CTL_B[charger_cfg_pkg::RECHG_LSB +: 2];
         pfm_q <= charger_cfg_pkg::RST_CTL_C[charger_cfg_pkg::PFM_BIT];
      end else begin
         if (wr_b) begin
            rechg_q <= wr_data[charger_cfg_pkg::RECHG_LSB +: 2];
         end
         if (wr_c) begin
            pfm_q <= wr_data[charger_cfg_pkg::PFM_BIT];
         end
      end
   end

   // Kick: a new write wins over the self-clear
   always_ff @(posedge clk_i) begin
      if (!nrst_i || reg_reset_cmd_i || wd_expire) begin
         kick_q <= charger_cfg_pkg::RST_CTL_C[charger_cfg_pkg::KICK_BIT];
      end else begin
         kick_q <= kick_set;  // [RL7]
      end
   end

   // ***************************************************************
   // Read images
   // ***************************************************************
   assign img_b = {1'b0, auto_q, tlim_q, chg_q, lowv_q, rechg_q};  // [RL14]
   assign img_c = {pfm_q, kick_q, topoff_q, charger_cfg_pkg::CTL_C_RSVD_READ};  // [RL9]
   assign img_z = {3'b000, vset_q, iseth_q, isetc_q};  // [RL16]

   always_comb begin
      if (ptr == charger_cfg_pkg::ADDR_CTL_B) begin
         rdata_d = img_b;
      end else if (ptr == charger_cfg_pkg::ADDR_CTL_C) begin
         rdata_d = img_c;
      end else if (ptr == charger_cfg_pkg::ADDR_ZONE) begin
         rdata_d = img_z;
      end else if (ptr == charger_cfg_pkg::ADDR_OPT) begin
         rdata_d = {3'b000, optimizer_limit_i};
      end else begin
         rdata_d = 8'h00;  // [RL13]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ***************************************************************
   // Decoded controls
   // ***************************************************************
   logic supply_q, detect_d, topoff_en_d, warm_susp_d, warm_hold_d, cool_susp_d;
   logic [7:0] temp_d, rechg_mv_d;
   logic [11:0] lowv_d;
   logic [5:0] topoff_d;
   logic [13:0] warm_mv_d;
   logic [6:0] warm_pct_d, cool_pct_d;

   assign detect_d = supply_present_i & ~supply_q & auto_q;  // [RL1]

   assign temp_d = (tlim_q == 2'b00) ? charger_cfg_pkg::TEMP_C_00 :
                   (tlim_q == 2'b01) ? charger_cfg_pkg::TEMP_C_01 :
                   (tlim_q == 2'b10) ? charger_cfg_pkg::TEMP_C_10 :
                   charger_cfg_pkg::TEMP_C_11;  // [RL2]

   assign lowv_d = lowv_q ? charger_cfg_pkg::LOWV_MV_1 : charger_cfg_pkg::LOWV_MV_0;  // [RL4]

   assign rechg_mv_d = charger_cfg_pkg::RECHG_BASE_MV
                     + (rechg_q[1] ? charger_cfg_pkg::RECHG_B1_MV : 8'h00)
                     + (rechg_q[0] ? charger_cfg_pkg::RECHG_B0_MV : 8'h00);  // [RL5]

   assign topoff_en_d = (topoff_q != 2'b00);  // [RL8]
   assign topoff_d = (topoff_q == 2'b01) ? charger_cfg_pkg::TOPOFF_MIN_01 :
                     (topoff_q == 2'b10) ? charger_cfg_pkg::TOPOFF_MIN_10 :
                     (topoff_q == 2'b11) ? charger_cfg_pkg::TOPOFF_MIN_11 : 6'h00;  // [RL8]

   assign warm_susp_d = (vset_q == 2'b00);  // [RL10]
   assign warm_hold_d = (vset_q == 2'b11);
   assign warm_mv_d = (vset_q == 2'b10) ? charger_cfg_pkg::WARM_MV_10 :
                      charger_cfg_pkg::WARM_MV_01;
   assign warm_pct_d = iseth_q ? charger_cfg_pkg::PCT_100 : charger_cfg_pkg::PCT_40;  // [RL11]

   assign cool_susp_d = (isetc_q == 2'b00);  // [RL12]
   assign cool_pct_d = (isetc_q == 2'b10) ? charger_cfg_pkg::PCT_40 :
                       (isetc_q == 2'b11) ? charger_cfg_pkg::PCT_100 :
                       (isetc_q == 2'b01) ? charger_cfg_pkg::PCT_20 : 7'h00;

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         supply_q <= 1'b0;
         detect_start_o <= 1'b0;
         die_temp_limit_o <= 8'h00;
         charge_enable_o <= 1'b0;
         boost_enable_o <= 1'b0;
         precharge_exit_mv_o <= 12'h000;
         recharge_offset_mv_o <= 8'h00;
         pulse_mode_allowed_o <= 1'b0;
         topoff_enable_o <= 1'b0;
         topoff_minutes_o <= 6'h00;
         warm_suspend_o <= 1'b0;
         warm_voltage_hold_o <= 1'b0;
         warm_voltage_mv_o <= 14'h0000;
         warm_current_pct_o <= 7'h00;
         cool_suspend_o <= 1'b0;
         cool_current_pct_o <= 7'h00;
         watchdog_expired_o <= 1'b0;
      end else begin
         supply_q <= supply_present_i;
         detect_start_o <= detect_d;
         die_temp_limit_o <= temp_d;
         charge_enable_o <= chg_q;  // [RL3]
         boost_enable_o <= reverse_boost_enable_i & ~chg_q;  // [RL3]
         precharge_exit_mv_o <= lowv_d;
         recharge_offset_mv_o <= rechg_mv_d;
         pulse_mode_allowed_o <= ~pfm_q;  // [RL6]
         topoff_enable_o <= topoff_en_d;
         topoff_minutes_o <= topoff_d;
         warm_suspend_o <= warm_susp_d;
         warm_voltage_hold_o <= warm_hold_d;
         warm_voltage_mv_o <= warm_mv_d;
         warm_current_pct_o <= warm_pct_d;
         cool_suspend_o <= cool_susp_d;
         cool_current_pct_o <= cool_pct_d;
         watchdog_expired_o <= wd_expire;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   a_detect_start: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL1]
      supply_present_i && !supply_q && auto_q |=> detect_start_o ##1 !detect_start_o)
      else $error("detection start pulse missing");

   a_temp_limit: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL2]
      tlim_q == 2'b00 |=> die_temp_limit_o == 8'h3c)
      else $error("die temperature limit wrong");

   a_charge_priority: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL3]
      chg_q && reverse_boost_enable_i |=> charge_enable_o && !boost_enable_o)
      else $error("charge enable lost priority");

   a_precharge_sel: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL4]
      !lowv_q |=> precharge_exit_mv_o == 12'haf0)
      else $error("precharge threshold wrong");

   a_recharge_keep: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL5]
      wd_expire && !reg_reset_cmd_i && !wr_b |=> rechg_q == $past(rechg_q) && tlim_q == 2'b11)
      else $error("watchdog expiry touched recharge offset");

   a_pulse_mode: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL6]
      pfm_q |=> !pulse_mode_allowed_o)
      else $error("pulse mode not blocked");

   a_kick_clear: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL7]
      kick_set && !reg_reset_cmd_i && !wd_expire ##1 !kick_set |=> !kick_q)
      else $error("kick bit did not self clear");

   a_topoff_off: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL8]
      topoff_q == 2'b00 |=> !topoff_enable_o && topoff_minutes_o == 6'h00)
      else $error("top-off timer not disabled");

   a_ctl_c_rsvd: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL9]
      ptr == 8'h07 |=> rdata_q[3:0] == 4'b0010)
      else $error("reserved bits of 07h read wrong");

   a_warm_volt: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL10]
      vset_q == 2'b10 |=> warm_voltage_mv_o == 14'h206c && !warm_suspend_o)
      else $error("warm zone voltage wrong");

   a_rsvd_zero: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL13]
      ptr == 8'h09 |=> rdata_q == 8'h00)
      else $error("reserved register not zero");

   a_b_bit7: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL14]
      ptr == 8'h06 |=> !rdata_q[7])
      else $error("06h bit 7 not zero");

   a_regrst_vals: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL15]
      reg_reset_cmd_i |=> img_b == 8'h7d && img_z == 8'h0d && !pfm_q && topoff_q == 2'b00)
      else $error("reset command values wrong");

   a_zone_write: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL18]
      wr_z && !reg_reset_cmd_i && !wd_expire |=> img_z == {3'b000, $past(wr_data[4:0])})
      else $error("zone register write not taken");

   a_cool_pct: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RL12]
      isetc_q == 2'b01 |=> cool_current_pct_o == 7'h14 && !cool_suspend_o)
      else $error("cool zone current wrong");
endmodule

// File: test/i2c_host_model.sv
// Two-wire host model: pointer write, then data write or repeated-start read.
// Assumes the bench resolves the pulled-up data line from both sides.
`timescale 1ns/1ns
module i2c_host_model #(
   parameter logic [6:0] ADDR = 7'h55
) (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o = 1'b1,
   output logic sda_low_o = 1'b0,
   output logic [7:0] rd_byte_o = 8'h00,
   output logic rd_done_o = 1'b0
);
   task automatic half();
      repeat (4) @(posedge clk_i);
      #1;
   endtask
   task automatic bit_io(input logic b, output logic s);
      sda_low_o = ~b;
      half();
      scl_o = 1'b1;
      half();
      s = sda_i;
      scl_o = 1'b0;
      half();
   endtask
   task automatic frame(input logic stop);
      sda_low_o = stop;
      half();
      scl_o = 1'b1;
      half();
      sda_low_o = ~stop;
      half();
      if (!stop) begin
         scl_o = 1'b0;
         half();
      end
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'b1, a);
   endtask
   task automatic access(input logic [7:0] ptr, input logic rd, input logic [7:0] wd);
      logic [7:0] q;
      logic a;
      frame(1'b0);
      xfer({ADDR, 1'b0}, q, a);
      xfer(ptr, q, a);
      if (rd) begin
         frame(1'b0);
         xfer({ADDR, 1'b1}, q, a);
         xfer(8'hff, q, a);
         rd_byte_o = q;
         rd_done_o = 1'b1;
      end else begin
         xfer(wd, q, a);
      end
      frame(1'b1);
      rd_done_o = 1'b0;
   endtask
endmodule

// File: test/test_charger_control_config_regs.sv
// Self-checking bench for the charger configuration bank.
// Assumes the host model and a pulled-up data line.
`timescale 1ns/1ns
module test_charger_control_config_regs;
   logic clk = 1'b0, nrst = 1'b0, rst_cmd = 1'b0, supply = 1'b0, boost = 1'b0;
   logic [1:0] wdp = 2'h0;
   logic [4:0] opt = 5'h00;
   logic scl, sda_low, sda_oe, sdo, rd_done, det, expd, chg, bst, pulse_ok, topoff_en;
   logic warm_sus, warm_hold, cool_sus;
   logic [7:0] rd_byte, temp, rechg, d;
   logic [11:0] lowv;
   logic [5:0] tmin;
   logic [13:0] warm_mv;
   logic [6:0] warm_pct, cool_pct;
   logic [6:0] pct [4] = '{7'd0, 7'd20, 7'd40, 7'd100};
   logic [15:0] exp_q[$];
   int num_errors = 0, compares = 0, det_cnt = 0, exp_cnt = 0;
   wire sda = ~(sda_low | (sda_oe & ~sdo));
   always #20 clk = ~clk;
   always @(posedge clk) begin
      if (det) det_cnt++;
      if (expd) exp_cnt++;
   end
   charger_control_config_regs #(.TICKS_PER_SEC(4)) uut (.clk_i(clk), .nrst_i(nrst),
      .scl_i(scl), .sda_i(sda), .sda_o(sdo), .sda_oe_o(sda_oe), .reg_reset_cmd_i(rst_cmd),
      .watchdog_period_i(wdp), .supply_present_i(supply), .reverse_boost_enable_i(boost),
      .optimizer_limit_i(opt), .detect_start_o(det), .die_temp_limit_o(temp),
      .charge_enable_o(chg), .boost_enable_o(bst), .precharge_exit_mv_o(lowv),
      .recharge_offset_mv_o(rechg), .pulse_mode_allowed_o(pulse_ok),
      .topoff_enable_o(topoff_en), .topoff_minutes_o(tmin), .warm_suspend_o(warm_sus),
      .warm_voltage_hold_o(warm_hold), .warm_voltage_mv_o(warm_mv),
      .warm_current_pct_o(warm_pct), .cool_suspend_o(cool_sus),
      .cool_current_pct_o(cool_pct), .watchdog_expired_o(expd));
   i2c_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low),
      .rd_byte_o(rd_byte), .rd_done_o(rd_done));
   // ***************************************************************
   // Checking
   // ***************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({8'h00, e});
      host.access(a, 1'b1, 8'h00);
   endtask
   always @(posedge rd_done) chk({8'h00, rd_byte}, exp_q.pop_front());
   task automatic final_report();
      $display("counts: %0d compares, %0d errors", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #2400000;
      num_errors++;
      final_report();
   end
   initial begin
      opt = 5'($urandom(32'hde784f46));
      repeat (5) @(posedge clk);
      #1 nrst = 1'b1;
      rd(8'h06, 8'h7d);
      rd(8'h07, 8'h02);
      rd(8'h08, 8'h0d);
      rd(8'h0a, {3'h0, opt});
      chk(16'({temp, chg, rechg[6:0]}), 16'({8'd120, 1'b1, 7'd100}));
      chk(16'({lowv, pulse_ok, topoff_en}), 16'({12'd3000, 2'b10}));
      chk(16'({warm_pct, cool_pct}), 16'({7'd100, 7'd20}));
      $display("reset values done");
      boost = 1'b1;
      for (int i = 0; i < 4; i++) begin
         host.access(8'h06, 1'b0, {2'b10, 2'(i), 2'b00, 2'(i)});
         rd(8'h06, {2'b00, 2'(i), 2'b00, 2'(i)});
         chk(16'({temp, rechg}), 16'({8'(60 + 20 * i), 8'(50 + 50 * i)}));
         chk(16'({chg, bst, lowv}), 16'({2'b01, 12'd2800}));
      end
      supply = 1'b1;
      repeat (4) @(posedge clk);
      #1 supply = 1'b0;
      host.access(8'h06, 1'b0, 8'h7d);
      chk(16'(bst), 16'h0000);
      supply = 1'b1;
      repeat (4) @(posedge clk);
      chk(16'(det_cnt), 16'h0001);
      $display("control b done");
      for (int i = 0; i < 4; i++) begin
         host.access(8'h07, 1'b0, {i[0], 1'b0, 2'(i), 4'hf});
         rd(8'h07, {i[0], 1'b0, 2'(i), 4'h2});
         chk(16'({tmin, topoff_en, pulse_ok}), 16'({6'(15 * i), i != 0, !i[0]}));
      end
      $display("control c done");
      for (int i = 0; i < 4; i++) begin
         d = {3'($urandom()), 2'(i), i[0], 2'(i)};
         host.access(8'h08, 1'b0, d);
         rd(8'h08, {3'h0, d[4:0]});
         chk(16'({warm_sus, warm_hold, cool_sus}), 16'({i == 0, i == 3, i == 0}));
         chk(16'(warm_mv), i == 2 ? 16'd8300 : 16'd8000);
         chk(16'({warm_pct, cool_pct}), 16'({i[0] ? 7'd100 : 7'd40, pct[i]}));
      end
      host.access(8'h09, 1'b0, 8'hff);
      rd(8'h09, 8'h00);
      $display("zone and reserved done");
      host.access(8'h06, 1'b0, 8'h02);
      host.access(8'h07, 1'b0, 8'hb0);
      wdp = 2'h3;
      host.access(8'h07, 1'b0, 8'hf0);
      repeat (400) @(posedge clk);
      chk(16'(exp_cnt), 16'h0000);
      for (int n = 0; n < 400 && exp_cnt == 0; n++) @(posedge clk);
      #1 wdp = 2'h0;
      chk(16'(exp_cnt), 16'h0001);
      rd(8'h06, 8'h7e);
      rd(8'h07, 8'h82);
      $display("watchdog done");
      rst_cmd = 1'b1;
      @(posedge clk);
      #1 rst_cmd = 1'b0;
      rd(8'h06, 8'h7d);
      rd(8'h07, 8'h02);
      $display("reset command done");
      final_report();
   end
endmodule
